// ---- logic/ldo_sleep_and_discharge_regs.v ----
// Control registers for auxiliary regulator three and the rail discharge fields.
// Assumes a synchronous byte register port and factory values presented at FACT_LOAD_I.
//
// Summary of operation
// - Control at 29h; 7:6 RO, 5:4 sleep, 0 enable
// - Sleep 00 normal code; 11 sleep code when pin low
// - Factory picks sleep pin one or two
// - Enable bit 0 forces regulator off, overriding pins
// - Discharge codes: none, 100, 200, 500 ohms
// - Discharge field clears when its rail enables
// - Discharge one at 40h: bucks four..one
// - Discharge two at 41h: aux two, A1, six, five
// - Discharge three at 42h: B2, B1, aux three; 7:6 zero
//
// Register map
//   29h: 7:6 read zero, 5:4 sleep select, 3:1 stored as written, 0 enable
//   40h: buck four, buck three, buck two, buck one, high pair first
//   41h: aux two, switch A1, buck six, buck five, high pair first
//   42h: 7:6 read zero, then switch B2, switch B1, aux three
//
// Timing
//   A write lands at the edge that samples WR_I; a read answers one cycle later.
//   RDATA_O holds until the next read, RVALID_O stands for one cycle.
//   CE_I low freezes every register, the read answer included.
//
// Limitations
//   Registers read zero after reset until FACT_LOAD_I delivers the factory image or software writes them.
//   Sleep codes 01 and 10 are stored but steer like 00.
//   The discharge clear follows the rising rail enable, so software may
//   arm a pull-down again while its rail stays on.
`timescale 1ns/1ps
`default_nettype none
`include "ldo_discharge_defs.vh"

module ldo_sleep_and_discharge_regs
#(
  parameter RAILS = `RAIL_COUNT
)
(
  // Clock, reset, enable
  input wire CLK_I,
  input wire RESET_I,
  input wire CE_I,
  // Register port
  input wire [7:0] ADDR_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] WDATA_I,
  output reg [7:0] RDATA_O,
  output reg RVALID_O,
  // Factory configuration
  input wire FACT_LOAD_I,
  input wire FACT_PIN_SEL_I,
  input wire [7:0] FACT_AUX3_I,
  input wire [7:0] FACT_DISCH_ONE_I,
  input wire [7:0] FACT_DISCH_TWO_I,
  input wire [7:0] FACT_DISCH_THREE_I,
  // Sleep pins and pin requests
  input wire SLEEP_PIN_ONE_I,
  input wire SLEEP_PIN_TWO_I,
  input wire AUX3_PIN_REQ_I,
  // Rail enables
  input wire [RAILS-1:0] RAIL_EN_I,
  // Regulator controls
  output reg AUX3_ON_O,
  output reg AUX3_USE_SLEEP_O,
  output wire [3*RAILS-1:0] PULLDOWN_SEL_O
);

  // ========================================================================
  // Storage
  reg [7:0] aux3_r;
  reg pin_sel_r;
  wire [2*RAILS-1:0] fields;
  wire wr_aux3 = WR_I & (ADDR_I == `AUX3_CTRL_ADDR);
  wire wr_one = WR_I & (ADDR_I == `DISCH_ONE_ADDR);
  wire wr_two = WR_I & (ADDR_I == `DISCH_TWO_ADDR);
  wire wr_three = WR_I & (ADDR_I == `DISCH_THREE_ADDR);

  // ========================================================================
  // Discharge fields, one per rail; each sits in fields at twice its rail index
  // Buck one: 40h, lowest pair
  pulldown_field u_buck_one
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_ONE_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_one),
    .wr_val_i(WDATA_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_ONE]),
    .field_o(fields[2 * `RAIL_BUCK_ONE +: `FIELD_WIDTH])
  );
  // Buck two: 40h, second pair
  pulldown_field u_buck_two
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_ONE_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .wr_i(wr_one),
    .wr_val_i(WDATA_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_TWO]),
    .field_o(fields[2 * `RAIL_BUCK_TWO +: `FIELD_WIDTH])
  );
  // Buck three: 40h, third pair
  pulldown_field u_buck_three
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_ONE_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_one),
    .wr_val_i(WDATA_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_THREE]),
    .field_o(fields[2 * `RAIL_BUCK_THREE +: `FIELD_WIDTH])
  );
  // Buck four: 40h, top pair
  pulldown_field u_buck_four
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_ONE_I[`SLOT_FOUR_LO +: `FIELD_WIDTH]),
    .wr_i(wr_one),
    .wr_val_i(WDATA_I[`SLOT_FOUR_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_FOUR]),
    .field_o(fields[2 * `RAIL_BUCK_FOUR +: `FIELD_WIDTH])
  );
  // Buck five: 41h, lowest pair
  pulldown_field u_buck_five
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_TWO_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_two),
    .wr_val_i(WDATA_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_FIVE]),
    .field_o(fields[2 * `RAIL_BUCK_FIVE +: `FIELD_WIDTH])
  );
  // Buck six: 41h, second pair
  pulldown_field u_buck_six
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_TWO_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .wr_i(wr_two),
    .wr_val_i(WDATA_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_BUCK_SIX]),
    .field_o(fields[2 * `RAIL_BUCK_SIX +: `FIELD_WIDTH])
  );
  // Switch A1: 41h, third pair
  pulldown_field u_switch_a1
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_TWO_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_two),
    .wr_val_i(WDATA_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_SWITCH_A1]),
    .field_o(fields[2 * `RAIL_SWITCH_A1 +: `FIELD_WIDTH])
  );
  // Aux regulator two: 41h, top pair
  pulldown_field u_aux_two
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_TWO_I[`SLOT_FOUR_LO +: `FIELD_WIDTH]),
    .wr_i(wr_two),
    .wr_val_i(WDATA_I[`SLOT_FOUR_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_AUX_TWO]),
    .field_o(fields[2 * `RAIL_AUX_TWO +: `FIELD_WIDTH])
  );
  // Aux regulator three: 42h, lowest pair
  pulldown_field u_aux_three
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_THREE_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_three),
    .wr_val_i(WDATA_I[`SLOT_ONE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_AUX_THREE]),
    .field_o(fields[2 * `RAIL_AUX_THREE +: `FIELD_WIDTH])
  );
  // Switch B1: 42h, second pair
  pulldown_field u_switch_b1
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_THREE_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .wr_i(wr_three),
    .wr_val_i(WDATA_I[`SLOT_TWO_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_SWITCH_B1]),
    .field_o(fields[2 * `RAIL_SWITCH_B1 +: `FIELD_WIDTH])
  );
  // Switch B2: 42h, third pair; the top pair is never stored
  pulldown_field u_switch_b2
  (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .load_i(FACT_LOAD_I),
    .load_val_i(FACT_DISCH_THREE_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .wr_i(wr_three),
    .wr_val_i(WDATA_I[`SLOT_THREE_LO +: `FIELD_WIDTH]),
    .rail_en_i(RAIL_EN_I[`RAIL_SWITCH_B2]),
    .field_o(fields[2 * `RAIL_SWITCH_B2 +: `FIELD_WIDTH])
  );

  // ========================================================================
  // Resistor selects, one decoder per rail
  genvar g;
  generate
    for (g = 0; g < RAILS; g = g + 1)
    begin : rail
      pulldown_decode u_dec
      (
        .code_i(fields[2*g+1:2*g]),
        .sel_o(PULLDOWN_SEL_O[3*g+2:3*g])
      );
    end
  endgenerate

  // ========================================================================
  // Control register; top bits never stored, so they read zero
  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      aux3_r <= 8'h00;
      pin_sel_r <= 1'b0;
    end
    else if (CE_I)
    begin
      if (FACT_LOAD_I)
      begin
        aux3_r <= FACT_AUX3_I & `AUX3_WRITE_MASK;
        pin_sel_r <= FACT_PIN_SEL_I;
      end
      else if (wr_aux3)
        aux3_r <= WDATA_I & `AUX3_WRITE_MASK;
    end
  end

  // ========================================================================
  // Regulator steering; sleep pins are active low
  wire sleep_pin = pin_sel_r ? SLEEP_PIN_TWO_I : SLEEP_PIN_ONE_I;
  wire sleep_armed = (aux3_r[`AUX3_SLEEP_HI:`AUX3_SLEEP_LO] == `SLEEP_SEL_ON);

  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      AUX3_ON_O <= 1'b0;
      AUX3_USE_SLEEP_O <= 1'b0;
    end
    else if (CE_I)
    begin
      // Cleared enable bit beats any pin request
      AUX3_ON_O <= aux3_r[`AUX3_ENABLE_BIT] & AUX3_PIN_REQ_I;
      // Reserved codes 01/10 behave as normal code
      AUX3_USE_SLEEP_O <= sleep_armed & ~sleep_pin;
    end
  end

  // ========================================================================
  // Read path, one cycle latency; unmapped reads return zero
  reg [7:0] rd_nxt;
  always @*
  begin
    rd_nxt = 8'h00;
    if (ADDR_I == `AUX3_CTRL_ADDR)
      rd_nxt = aux3_r;
    else if (ADDR_I == `DISCH_ONE_ADDR)
      rd_nxt = fields[7:0];
    else if (ADDR_I == `DISCH_TWO_ADDR)
      rd_nxt = fields[15:8];
    else if (ADDR_I == `DISCH_THREE_ADDR)
      rd_nxt = {2'h0, fields[21:16]};
  end

  always @(posedge CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      RDATA_O <= 8'h00;
      RVALID_O <= 1'b0;
    end
    else if (CE_I)
    begin
      RVALID_O <= RD_I;
      if (RD_I)
        RDATA_O <= rd_nxt;
    end
  end

endmodule // ldo_sleep_and_discharge_regs
`default_nettype wire

// ---- logic/ldo_discharge_defs.vh ----
// Constants for the auxiliary regulator three control and discharge registers.
// Assumes a plain byte-wide register port: 8-bit address, 8-bit data.
`ifndef LDO_DISCHARGE_DEFS_VH
`define LDO_DISCHARGE_DEFS_VH

// ==========================================================================
// Register offsets
`define AUX3_CTRL_ADDR 8'h29
`define DISCH_ONE_ADDR 8'h40
`define DISCH_TWO_ADDR 8'h41
`define DISCH_THREE_ADDR 8'h42

// ==========================================================================
// Auxiliary regulator three control fields
`define AUX3_SLEEP_HI 5
`define AUX3_SLEEP_LO 4
`define AUX3_RSVD_HI 3
`define AUX3_RSVD_LO 1
`define AUX3_ENABLE_BIT 0
`define SLEEP_SEL_OFF 2'h0
`define SLEEP_SEL_ON 2'h3
`define AUX3_RSVD_PATTERN 3'h6
`define AUX3_WRITE_MASK 8'h3F

// ==========================================================================
// Discharge encodings
`define PULLDOWN_NONE 2'h0
`define PULLDOWN_100R 2'h1
`define PULLDOWN_200R 2'h2
`define PULLDOWN_500R 2'h3
`define DISCH_THREE_MASK 8'h3F
`define FIELDS_PER_REG 4
`define FIELD_WIDTH 2
`define SLOT_ONE_LO 0
`define SLOT_TWO_LO 2
`define SLOT_THREE_LO 4
`define SLOT_FOUR_LO 6

// ==========================================================================
// Rail indices in the rail enable vector
`define RAIL_BUCK_ONE 0
`define RAIL_BUCK_TWO 1
`define RAIL_BUCK_THREE 2
`define RAIL_BUCK_FOUR 3
`define RAIL_BUCK_FIVE 4
`define RAIL_BUCK_SIX 5
`define RAIL_SWITCH_A1 6
`define RAIL_AUX_TWO 7
`define RAIL_AUX_THREE 8
`define RAIL_SWITCH_B1 9
`define RAIL_SWITCH_B2 10
`define RAIL_COUNT 11

`endif

// ---- logic/pulldown_field.v ----
// One 2-bit discharge field with a clear on its rail's enable.
// Assumes rail enable is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "ldo_discharge_defs.vh"

module pulldown_field
(
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  input wire ce_i,
  // Load from factory memory
  input wire load_i,
  input wire [1:0] load_val_i,
  // Software write
  input wire wr_i,
  input wire [1:0] wr_val_i,
  // Rail state
  input wire rail_en_i,
  // Field value
  output reg [1:0] field_o
);

  // ========================================================================
  // Field storage
  reg rail_en_r;
  wire rail_rise = rail_en_i & ~rail_en_r;

  // Enable edge beats a coincident load or write; a later write while the rail stays on still lands
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      field_o <= `PULLDOWN_NONE;
      rail_en_r <= 1'b0;
    end
    else if (ce_i)
    begin
      rail_en_r <= rail_en_i;
      if (rail_rise | (load_i & rail_en_i))
        field_o <= `PULLDOWN_NONE;
      else if (load_i)
        field_o <= load_val_i;
      else if (wr_i)
        field_o <= wr_val_i;
    end
  end

endmodule // pulldown_field
`default_nettype wire

// ---- logic/pulldown_decode.v ----
// Turns a 2-bit discharge code into one-hot resistor selects.
// Purely combinational; output is sampled by the analog side.
`timescale 1ns/1ps
`default_nettype none
`include "ldo_discharge_defs.vh"

module pulldown_decode
(
  // Code in
  input wire [1:0] code_i,
  // Resistor selects: 100, 200, 500 ohm
  output wire [2:0] sel_o
);

  // ========================================================================
  // Decode, none selected for no discharge
  assign sel_o[0] = (code_i == `PULLDOWN_100R);
  assign sel_o[1] = (code_i == `PULLDOWN_200R);
  assign sel_o[2] = (code_i == `PULLDOWN_500R);

endmodule // pulldown_decode
`default_nettype wire

// ---- verif/ldo_regs_monitor.sv ----
// Port-level checker for the regulator three and discharge registers.
// Assumes no read is issued while CE_I is low; bound to the top module from the testbench.
`timescale 1ns/1ps
`default_nettype none
module ldo_regs_monitor
#(
  parameter RAILS = 11
)
(
  // Clock, reset and register port
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic [7:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic RVALID_O,
  // Pins and rail controls
  input wire logic SLEEP_PIN_ONE_I,
  input wire logic SLEEP_PIN_TWO_I,
  input wire logic AUX3_PIN_REQ_I,
  input wire logic [RAILS-1:0] RAIL_EN_I,
  input wire logic AUX3_ON_O,
  input wire logic AUX3_USE_SLEEP_O,
  input wire logic [3*RAILS-1:0] PULLDOWN_SEL_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  // ==========================================================================
  // Read answers and read-only bits
  AST_READ_ANSWERED: assert property (RD_I |=> RVALID_O) else $error("no rvalid");
  AST_NO_SPURIOUS_VALID: assert property (!RD_I |=> !RVALID_O) else $error("extra rvalid");
  AST_CTRL_TOP_ZERO: assert property (RD_I && ADDR_I == 8'h29 |=> RDATA_O[7:6] == 2'h0) else $error("29h top");
  AST_DISCH_TOP_ZERO: assert property (RD_I && ADDR_I == 8'h42 |=> RDATA_O[7:6] == 2'h0) else $error("42h top");
  // ==========================================================================
  // Regulator control and pull-down selects
  AST_ON_NEEDS_REQ: assert property (AUX3_ON_O |-> $past(AUX3_PIN_REQ_I)) else $error("on without req");
  AST_SLEEP_NEEDS_PIN: assert property (AUX3_USE_SLEEP_O |-> !$past(SLEEP_PIN_ONE_I) || !$past(SLEEP_PIN_TWO_I))
    else $error("sleep without pin");
  AST_SEL_ONEHOT: assert property ($onehot0(PULLDOWN_SEL_O[2:0]) && $onehot0(PULLDOWN_SEL_O[26:24]))
    else $error("select not onehot");
  AST_CLEAR_BUCK_FOUR: assert property ($rose(RAIL_EN_I[3]) |=> PULLDOWN_SEL_O[11:9] == 3'h0) else $error("b4 clr");
  AST_CLEAR_AUX_THREE: assert property ($rose(RAIL_EN_I[8]) |=> PULLDOWN_SEL_O[26:24] == 3'h0) else $error("a3 clr");
  // Main scenarios reached
  cover property (RVALID_O);
  cover property (AUX3_USE_SLEEP_O);
  cover property ($rose(RAIL_EN_I[8]));
endmodule // ldo_regs_monitor
`default_nettype wire

// ---- verif/test_ldo_sleep_and_discharge_regs.sv ----
// Directed testbench for the regulator three and discharge registers.
// Assumes CE_I dropped only around a write; factory inputs driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module test_ldo_sleep_and_discharge_regs;
  localparam logic [21:0] CODES = 22'h3F1BE4;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ld = 1'b0, psel = 1'b0;
  logic pin1 = 1'b1, pin2 = 1'b1, preq = 1'b0, ce = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, f_aux = 8'h00;
  logic [10:0] rail = 11'h000;
  wire [7:0] rdata;
  wire rvalid, on, slp;
  wire [32:0] sel;
  int miscompares = 0, n_compared = 0, i;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  ldo_sleep_and_discharge_regs dut (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .WDATA_I(wdata), .RDATA_O(rdata), .RVALID_O(rvalid), .FACT_LOAD_I(ld), .FACT_PIN_SEL_I(psel),
    .FACT_AUX3_I(f_aux), .FACT_DISCH_ONE_I(8'hA5), .FACT_DISCH_TWO_I(8'h5A), .FACT_DISCH_THREE_I(8'hFF),
    .SLEEP_PIN_ONE_I(pin1), .SLEEP_PIN_TWO_I(pin2), .AUX3_PIN_REQ_I(preq), .RAIL_EN_I(rail),
    .AUX3_ON_O(on), .AUX3_USE_SLEEP_O(slp), .PULLDOWN_SEL_O(sel));
  // ==========================================================================
  // Tasks
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Bounded wait for the answer; a lost one ends the run
  task rd_reg(input logic [7:0] a, e);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 4);
    chk({7'h0, rvalid}, 8'h01);
    if (rvalid !== 1'b1)
      conclude();
    chk(rdata, e);
  endtask
  task ld_fact(input logic s, input logic [7:0] a);
    @(posedge clk);
    psel <= s;
    f_aux <= a;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
  endtask
  // Outputs are registered, so let a few edges pass
  task chk_out(input logic e_on, e_slp);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({6'h0, on, slp}, {6'h0, e_on, e_slp});
  endtask
  function automatic logic [2:0] dec(input logic [1:0] c);
    return (c == 2'h0) ? 3'h0 : 3'h1 << (c - 2'h1);
  endfunction
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h40, 8'h00);
    ld_fact(1'b0, 8'hFF);
    rd_reg(8'h29, 8'h3F);
    rd_reg(8'h40, 8'hA5);
    rd_reg(8'h41, 8'h5A);
    rd_reg(8'h42, 8'h3F);
    @(posedge clk) preq <= 1'b1;
    chk_out(1'b1, 1'b0);
    @(posedge clk) pin2 <= 1'b0;
    chk_out(1'b1, 1'b0);
    @(posedge clk) pin1 <= 1'b0;
    chk_out(1'b1, 1'b1);
    wr_reg(8'h29, 8'h0C);
    chk_out(1'b0, 1'b0);
    rd_reg(8'h29, 8'h0C);
    ld_fact(1'b1, 8'h3D);
    @(posedge clk) pin2 <= 1'b1;
    chk_out(1'b1, 1'b0);
    @(posedge clk) pin2 <= 1'b0;
    chk_out(1'b1, 1'b1);
    @(posedge clk) preq <= 1'b0;
    chk_out(1'b0, 1'b1);
    wr_reg(8'h40, 8'hE4);
    wr_reg(8'h41, 8'h1B);
    wr_reg(8'h42, 8'hFF);
    rd_reg(8'h42, 8'h3F);
    for (i = 0; i < 11; i++)
      chk({5'h0, sel[3*i +: 3]}, {5'h0, dec(CODES[2*i +: 2])});
    @(posedge clk) rail <= 11'h108;
    rd_reg(8'h40, 8'h24);
    rd_reg(8'h42, 8'h3C);
    wr_reg(8'h50, 8'hFF);
    rd_reg(8'h50, 8'h00);
    // Write on the edge its rail rises: the clear wins
    @(posedge clk)
    begin
      addr <= 8'h40;
      wdata <= 8'h27;
      wr <= 1'b1;
      rail <= 11'h109;
    end
    @(posedge clk) wr <= 1'b0;
    rd_reg(8'h40, 8'h24);
    // Low clock enable drops a write
    @(posedge clk) ce <= 1'b0;
    wr_reg(8'h41, 8'hFF);
    @(posedge clk) ce <= 1'b1;
    rd_reg(8'h41, 8'h1B);
    // Second reset clears the registers again
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h41, 8'h00);
    rd_reg(8'h29, 8'h00);
    conclude();
  end
endmodule // test_ldo_sleep_and_discharge_regs
bind ldo_sleep_and_discharge_regs ldo_regs_monitor #(.RAILS(RAILS)) mon (.CLK_I(CLK_I), .RESET_I(RESET_I),
  .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .SLEEP_PIN_ONE_I(SLEEP_PIN_ONE_I),
  .SLEEP_PIN_TWO_I(SLEEP_PIN_TWO_I), .AUX3_PIN_REQ_I(AUX3_PIN_REQ_I), .RAIL_EN_I(RAIL_EN_I),
  .AUX3_ON_O(AUX3_ON_O), .AUX3_USE_SLEEP_O(AUX3_USE_SLEEP_O), .PULLDOWN_SEL_O(PULLDOWN_SEL_O));
`default_nettype wire
